// ==== logic/exec_pkg.sv ====
// Shared types and constants for the operate, skip, jump and index unit.
`default_nettype none
package exec_pkg;

	// Word layout: bit 0 is the most significant bit of every word and address.
	localparam int               WORD_W        = 18;
	localparam int               ADDR_W        = 15;
	localparam int               IMM_LSB_POS   = 9;
	localparam int               SWAP_POS      = 9;
	localparam int               JMS_LINK_POS  = 0;
	localparam int               JMS_PROT_POS  = 2;
	localparam int               JMS_PC_POS    = 3;

	// Reset values and fixed vectors.
	localparam logic [0:17]      ACC_RESET     = 18'h0_0000;
	localparam logic [0:17]      INDEX_RESET   = 18'h0_0000;
	localparam logic [0:17]      LIMIT_RESET   = 18'h0_0000;
	localparam logic             LINK_RESET    = 1'b0;
	localparam logic [0:14]      PC_RESET      = 15'h0000;
	localparam logic [0:14]      PC_STEP       = 15'h0001;
	localparam logic [0:14]      PC_SKIP_STEP  = 15'h0002;
	localparam logic [0:14]      MON_VECTOR    = 15'h0010;
	localparam logic [2:0]       API_RESET     = 3'h0;
	localparam logic [2:0]       API_MON_LEVEL = 3'h4;

	// Decoded instructions handed over by the fetch and decode stage.
	typedef enum logic [5:0]
	{
		OP_NO_OPERATION,
		OP_ROTATE_RIGHT_ONE,
		OP_ROTATE_RIGHT_TWO,
		OP_ROTATE_LEFT_ONE,
		OP_ROTATE_LEFT_TWO,
		OP_LINK_COMPLEMENT,
		OP_LINK_SET,
		OP_LINK_CLEAR,
		OP_ACC_CLEAR,
		OP_CONSOLE_OR_ACC,
		OP_ACC_INCREMENT,
		OP_HALT_INSTR,
		OP_ACC_HALF_SWAP,
		OP_ACC_INVERT,
		OP_ACC_NEGATE,
		OP_SELF_LOAD,
		OP_EXECUTE_AT_EA,
		OP_SKIP_ALWAYS,
		OP_JUMP_INSTR,
		OP_JUMP_SUBROUTINE,
		OP_MONITOR_CALL,
		OP_SKIP_ACC_POSITIVE,
		OP_SKIP_ACC_NEGATIVE,
		OP_SKIP_ACC_NONZERO,
		OP_SKIP_ACC_ZERO,
		OP_SKIP_LINK_SET,
		OP_SKIP_LINK_CLEAR,
		OP_ACC_TO_INDEX,
		OP_ACC_TO_LIMIT,
		OP_INDEX_TO_ACC,
		OP_INDEX_TO_LIMIT,
		OP_LIMIT_TO_ACC,
		OP_LIMIT_TO_INDEX,
		OP_ADD_ACC_SKIP_LIMIT,
		OP_ADD_INDEX_SKIP_LIMIT,
		OP_ADD_INDEX_IMM,
		OP_ADD_ACC_IMM,
		OP_INDEX_CLEAR,
		OP_LIMIT_CLEAR
	} op_e;

	typedef enum logic [1:0]
	{
		ST_RUN,
		ST_HALTED,
		ST_MON_INDIRECT
	} state_e;

	// One dispatched instruction: code, raw word, effective address.
	typedef struct packed
	{
		op_e         op;
		logic        indirect;
		logic [0:17] word;
		logic [0:14] ea;
	} instr_s;

	// Request toward memory and the fetch stage.
	typedef struct packed
	{
		logic        wr;
		logic        rd;
		logic        execute_at_ea;
		logic [0:14] addr;
		logic [0:17] data;
	} mem_req_s;

	// Raw console pins.
	typedef struct packed
	{
		logic        cont;
		logic        restart;
		logic [0:17] acc_sw;
		logic [0:14] addr_sw;
	} console_s;

	localparam int CONSOLE_W = $bits(console_s);

endpackage
`default_nettype wire

// ==== logic/pin_filter.sv ====
// Three-stage input synchroniser with second/third stage agreement.
`timescale 1ns/100ps
`default_nettype none
module pin_filter
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset.
	input  wire logic             core_clk_in,
	input  wire logic             resetn_in,
	// Pins and filtered levels.
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);

	////////////////////////////////////////////////////////////////////////
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			logic s1_r;
			logic s2_r;
			logic s3_r;
			logic lvl_r;
			logic lvl_nxt;

			// The level moves only once two settled stages agree.
			always_comb
			begin
				lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
			end

			// The first stage feeds only the second, never any logic.
			always_ff @(posedge core_clk_in or negedge resetn_in)
			begin
				if (!resetn_in)
				begin
					s1_r  <= 1'b0;
					s2_r  <= 1'b0;
					s3_r  <= 1'b0;
					lvl_r <= 1'b0;
				end
				else
				begin
					s1_r  <= pin_in[g];
					s2_r  <= s1_r;
					s3_r  <= s2_r;
					lvl_r <= lvl_nxt;
				end
			end

			assign level_out[g] = lvl_r;
		end
	endgenerate

endmodule
`default_nettype wire

// ==== logic/operate_skip_jump_index_exec.sv ====
// Executes operate, skip, jump and index/limit instructions.
//
// How it works
// - Rotate right one through link ring.
// - Rotate right two through link ring.
// - Rotate left one through link ring.
// - Rotate left two through link ring.
// - No-op only advances program counter.
// - Link complement, set or clear only.
// - OR console switches into accumulator.
// - Increment accumulator; carry inverts link.
// - Halt until continue or restart button.
// - Swap accumulator halves, link unchanged.
// - Invert or negate the accumulator.
// - Load own instruction word into accumulator.
// - Execute word at address; counter unchanged.
// - Unconditional skip of next instruction.
// - Jump loads effective address into counter.
// - Subroutine call stores return word, jumps.
// - Monitor call to location 16, level 4.
// - Skip on accumulator sign bit.
// - Skip on accumulator zero or nonzero.
// - Skip on link set or clear.
// - Copy between accumulator, index and limit.
// - Add signed immediate, optional limit skip.
// - Clear index, limit or accumulator.
`timescale 1ns/100ps
`default_nettype none
module operate_skip_jump_index_exec
	import exec_pkg::*;
(
	// Clock and reset.
	input  wire logic        core_clk_in,
	input  wire logic        resetn_in,
	// Instruction dispatch.
	input  wire logic        instr_valid_in,
	input  wire instr_s      instr_in,
	output logic             ready_out,
	output logic             done_out,
	// Memory side.
	input  wire logic [0:17] mem_rdata_in,
	input  wire logic        mem_rvalid_in,
	input  wire logic        prot_mode_in,
	output mem_req_s         mem_req_out,
	// Console pins.
	input  wire console_s    console_in,
	output logic             halted_out,
	// Architectural state.
	output logic [0:14]      pc_out,
	output logic [0:17]      acc_out,
	output logic             link_out,
	output logic [0:17]      index_out,
	output logic [0:17]      limit_out,
	output logic [2:0]       api_level_out
);

	////////////////////////////////////////////////////////////////////////
	// Console pins come from outside the clock domain.
	logic [CONSOLE_W-1:0] con_lvl_w;
	console_s             con_w;

	pin_filter #(.WIDTH(CONSOLE_W)) u_console_filter
	(
		.core_clk_in (core_clk_in),
		.resetn_in   (resetn_in),
		.pin_in      (console_in),
		.level_out   (con_lvl_w)
	);

	assign con_w = console_s'(con_lvl_w);

	////////////////////////////////////////////////////////////////////////
	// Registers and their next values.
	// register widths
	state_e      state_r;
	state_e      state_nxt;
	logic [0:17] acc_r;
	logic [0:17] acc_nxt;
	logic        link_r;
	logic        link_nxt;
	logic [0:17] idx_r;
	logic [0:17] idx_nxt;
	logic [0:17] lim_r;
	logic [0:17] lim_nxt;
	logic [0:14] pc_r;
	logic [0:14] pc_nxt;
	logic [2:0]  api_r;
	logic [2:0]  api_nxt;
	logic        ready_r;
	logic        ready_nxt;
	logic        done_r;
	logic        done_nxt;
	mem_req_s    req_r;
	mem_req_s    req_nxt;
	logic        cont_d_r;
	logic        rst_d_r;

	// Helper values shared by the datapath and the checks.
	logic        take_w;
	logic [0:18] ring_w;
	logic [0:18] rr1_w;
	logic [0:18] rr2_w;
	logic [0:18] rl1_w;
	logic [0:18] rl2_w;
	logic [0:17] imm_w;
	logic [0:17] acc_sum_w;
	logic [0:17] idx_sum_w;
	logic [0:18] inc_w;
	logic [0:8]  acc_lo_w;
	logic [0:8]  acc_hi_w;
	logic        cont_rise_w;
	logic        rst_rise_w;
	logic [0:14] ret_pc_w;
	logic [0:14] ind_ea_w;

	// Build the stored return word of a subroutine call.
	function automatic logic [0:17] ret_word(input logic        lnk,
	                                         input logic        prot,
	                                         input logic [0:14] rpc);
		logic [0:17] w;
		w = ACC_RESET;
		w[JMS_LINK_POS] = lnk;
		w[JMS_PROT_POS] = prot;
		w[JMS_PC_POS:17] = rpc;
		return w;
	endfunction

	// The ring is link followed by the accumulator, bit 0 leftmost.
	always_comb
	begin
		// Gated by the registered ready, so nothing is taken while it is low.
		take_w      = instr_valid_in && ready_r;
		ring_w      = {link_r, acc_r};
		rr1_w       = {ring_w[18], ring_w[0:17]};
		rr2_w       = {ring_w[17:18], ring_w[0:16]};
		rl1_w       = {ring_w[1:18], ring_w[0]};
		rl2_w       = {ring_w[2:18], ring_w[0:1]};
		imm_w       = {{IMM_LSB_POS{instr_in.word[IMM_LSB_POS]}},
		               instr_in.word[IMM_LSB_POS:17]};
		acc_sum_w   = 18'(acc_r + imm_w);
		idx_sum_w   = 18'(idx_r + imm_w);
		inc_w       = 19'({1'b0, acc_r} + 19'h0_0001);
		acc_lo_w    = acc_r[SWAP_POS:17];
		acc_hi_w    = acc_r[0:SWAP_POS-1];
		cont_rise_w = con_w.cont && !cont_d_r;
		rst_rise_w  = con_w.restart && !rst_d_r;
		ret_pc_w    = 15'(pc_r + PC_STEP);
		ind_ea_w    = mem_rdata_in[JMS_PC_POS:17];
	end

	////////////////////////////////////////////////////////////////////////
	// Execution: every instruction finishes in the cycle it is taken,
	// except an indirect monitor call, which waits for its vector read.
	always_comb
	begin
		state_nxt = state_r;
		acc_nxt   = acc_r;
		link_nxt  = link_r;
		idx_nxt   = idx_r;
		lim_nxt   = lim_r;
		pc_nxt    = pc_r;
		api_nxt   = api_r;
		done_nxt  = 1'b0;
		req_nxt   = '0;
		case (state_r)
			ST_RUN:
			begin
				if (take_w)
				begin
					pc_nxt   = ret_pc_w;
					done_nxt = 1'b1;
					case (instr_in.op)
						OP_ROTATE_RIGHT_ONE: {link_nxt, acc_nxt} = rr1_w;
						OP_ROTATE_RIGHT_TWO: {link_nxt, acc_nxt} = rr2_w;
						OP_ROTATE_LEFT_ONE:  {link_nxt, acc_nxt} = rl1_w;
						OP_ROTATE_LEFT_TWO:  {link_nxt, acc_nxt} = rl2_w;
						OP_LINK_COMPLEMENT:  link_nxt = !link_r;
						OP_LINK_SET:         link_nxt = 1'b1;
						OP_LINK_CLEAR:       link_nxt = 1'b0;
						OP_CONSOLE_OR_ACC:   acc_nxt = acc_r | con_w.acc_sw;
						OP_ACC_INCREMENT:
						begin
							acc_nxt  = inc_w[1:18];
							link_nxt = link_r ^ inc_w[0];
						end
						OP_HALT_INSTR:       state_nxt = ST_HALTED;
						OP_ACC_HALF_SWAP:    acc_nxt = {acc_lo_w, acc_hi_w};
						OP_ACC_INVERT:       acc_nxt = ~acc_r;
						OP_ACC_NEGATE:       acc_nxt = 18'(~acc_r + 18'h0_0001);
						OP_SELF_LOAD:        acc_nxt = instr_in.word;
						// fetch stage runs the target next
						OP_EXECUTE_AT_EA:
						begin
							pc_nxt       = pc_r;
							req_nxt.execute_at_ea  = 1'b1;
							req_nxt.addr = instr_in.ea;
						end
						OP_SKIP_ALWAYS:      pc_nxt = 15'(pc_r + PC_SKIP_STEP);
						OP_JUMP_INSTR:       pc_nxt = instr_in.ea;
						OP_JUMP_SUBROUTINE:
						begin
							req_nxt.wr   = 1'b1;
							req_nxt.addr = instr_in.ea;
							req_nxt.data = ret_word(link_r, prot_mode_in,
							                        ret_pc_w);
							pc_nxt       = 15'(instr_in.ea + PC_STEP);
						end
						OP_MONITOR_CALL:
						begin
							api_nxt = API_MON_LEVEL;
							if (instr_in.indirect)
							begin
								req_nxt.rd   = 1'b1;
								req_nxt.addr = MON_VECTOR;
								pc_nxt       = pc_r;
								done_nxt     = 1'b0;
								state_nxt    = ST_MON_INDIRECT;
							end
							else
							begin
								req_nxt.wr   = 1'b1;
								req_nxt.addr = MON_VECTOR;
								req_nxt.data = ret_word(link_r, prot_mode_in,
								                        ret_pc_w);
								pc_nxt       = 15'(MON_VECTOR + PC_STEP);
							end
						end
						OP_SKIP_ACC_POSITIVE:
							if (!acc_r[0]) pc_nxt = 15'(pc_r + PC_SKIP_STEP);
						OP_SKIP_ACC_NEGATIVE:
							if (acc_r[0]) pc_nxt = 15'(pc_r + PC_SKIP_STEP);
						OP_SKIP_ACC_NONZERO:
							if (|acc_r) pc_nxt = 15'(pc_r + PC_SKIP_STEP);
						OP_SKIP_ACC_ZERO:
							if (~|acc_r) pc_nxt = 15'(pc_r + PC_SKIP_STEP);
						OP_SKIP_LINK_SET:
							if (link_r) pc_nxt = 15'(pc_r + PC_SKIP_STEP);
						OP_SKIP_LINK_CLEAR:
							if (!link_r) pc_nxt = 15'(pc_r + PC_SKIP_STEP);
						OP_ACC_TO_INDEX:     idx_nxt = acc_r;
						OP_ACC_TO_LIMIT:     lim_nxt = acc_r;
						OP_INDEX_TO_ACC:     acc_nxt = idx_r;
						OP_INDEX_TO_LIMIT:   lim_nxt = idx_r;
						OP_LIMIT_TO_ACC:     acc_nxt = lim_r;
						OP_LIMIT_TO_INDEX:   idx_nxt = lim_r;
						OP_ADD_ACC_SKIP_LIMIT:
						begin
							acc_nxt = acc_sum_w;
							if ($signed(acc_sum_w) >= $signed(lim_r))
								pc_nxt = 15'(pc_r + PC_SKIP_STEP);
						end
						OP_ADD_INDEX_SKIP_LIMIT:
						begin
							idx_nxt = idx_sum_w;
							if ($signed(idx_sum_w) >= $signed(lim_r))
								pc_nxt = 15'(pc_r + PC_SKIP_STEP);
						end
						OP_ADD_INDEX_IMM:    idx_nxt = idx_sum_w;
						OP_ADD_ACC_IMM:      acc_nxt = acc_sum_w;
						OP_INDEX_CLEAR:      idx_nxt = INDEX_RESET;
						OP_LIMIT_CLEAR:      lim_nxt = LIMIT_RESET;
						OP_ACC_CLEAR:        acc_nxt = ACC_RESET;
						default:             pc_nxt = ret_pc_w;
					endcase
				end
			end
			ST_HALTED:
			begin
				// restart beats continue if both arrive
				if (rst_rise_w)
				begin
					pc_nxt    = con_w.addr_sw;
					state_nxt = ST_RUN;
				end
				else if (cont_rise_w)
					state_nxt = ST_RUN;
			end
			ST_MON_INDIRECT:
			begin
				if (mem_rvalid_in)
				begin
					req_nxt.wr   = 1'b1;
					req_nxt.addr = ind_ea_w;
					req_nxt.data = ret_word(link_r, prot_mode_in, ret_pc_w);
					pc_nxt       = 15'(ind_ea_w + PC_STEP);
					done_nxt     = 1'b1;
					state_nxt    = ST_RUN;
				end
			end
			default: state_nxt = ST_RUN;
		endcase
		ready_nxt = (state_nxt == ST_RUN);
	end

	////////////////////////////////////////////////////////////////////////
	// Register update only.
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			state_r  <= ST_RUN;
			acc_r    <= ACC_RESET;
			link_r   <= LINK_RESET;
			idx_r    <= INDEX_RESET;
			lim_r    <= LIMIT_RESET;
			pc_r     <= PC_RESET;
			api_r    <= API_RESET;
			ready_r  <= 1'b0;
			done_r   <= 1'b0;
			req_r    <= '0;
			cont_d_r <= 1'b0;
			rst_d_r  <= 1'b0;
		end
		else
		begin
			state_r  <= state_nxt;
			acc_r    <= acc_nxt;
			link_r   <= link_nxt;
			idx_r    <= idx_nxt;
			lim_r    <= lim_nxt;
			pc_r     <= pc_nxt;
			api_r    <= api_nxt;
			ready_r  <= ready_nxt;
			done_r   <= done_nxt;
			req_r    <= req_nxt;
			cont_d_r <= con_w.cont;
			rst_d_r  <= con_w.restart;
		end
	end

	// Every output except halted_out is a flip-flop; halted_out decodes state_r.
	assign ready_out     = ready_r;
	assign done_out      = done_r;
	assign mem_req_out   = req_r;
	assign halted_out    = (state_r == ST_HALTED);
	assign pc_out        = pc_r;
	assign acc_out       = acc_r;
	assign link_out      = link_r;
	assign index_out     = idx_r;
	assign limit_out     = lim_r;
	assign api_level_out = api_r;

	////////////////////////////////////////////////////////////////////////
	// Checks on the execution results.
	// rotate right one check
	rot_right_one_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		take_w && instr_in.op == OP_ROTATE_RIGHT_ONE |=>
		acc_r[0] == $past(link_r) && link_r == $past(acc_r[17]))
		else $error("rotate right one moved the wrong bits");

	rot_left_two_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		take_w && instr_in.op == OP_ROTATE_LEFT_TWO |=>
		acc_r[16] == $past(link_r) && acc_r[17] == $past(acc_r[0]))
		else $error("rotate left two moved the wrong bits");

	incr_carry_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		take_w && instr_in.op == OP_ACC_INCREMENT && &acc_r |=>
		acc_r == ACC_RESET && link_r != $past(link_r))
		else $error("increment carry did not invert the link");

	half_swap_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		take_w && instr_in.op == OP_ACC_HALF_SWAP |=>
		acc_hi_w == $past(acc_lo_w) && $stable(link_r))
		else $error("half swap result is wrong");

	skip_pc_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		take_w && instr_in.op == OP_SKIP_ALWAYS |=>
		pc_r == 15'($past(pc_r) + PC_SKIP_STEP) ##1 ready_out)
		else $error("skip did not advance the counter by two");

	jms_store_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		take_w && instr_in.op == OP_JUMP_SUBROUTINE |=>
		req_r.wr && req_r.data[JMS_PC_POS:17] == $past(ret_pc_w) &&
		req_r.data[JMS_LINK_POS] == $past(link_r))
		else $error("subroutine call stored a wrong word");

	mon_call_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		take_w && instr_in.op == OP_MONITOR_CALL && !instr_in.indirect |=>
		api_level_out == API_MON_LEVEL && req_r.addr == MON_VECTOR &&
		pc_r == 15'(MON_VECTOR + PC_STEP))
		else $error("monitor call went to the wrong place");

	halt_hold_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		halted_out && !cont_rise_w && !rst_rise_w |=>
		halted_out && $stable(pc_r) && $stable(acc_r) && !done_out)
		else $error("halt did not hold the machine");

	xct_keep_a: assert property (@(posedge core_clk_in)
		disable iff (!resetn_in)
		take_w && instr_in.op == OP_EXECUTE_AT_EA |=>
		$stable(pc_r) && req_r.execute_at_ea && !req_r.wr)
		else $error("execute moved the counter");

endmodule
`default_nettype wire

// ==== verification/mem_console_model.sv ====
// Memory and console model facing the execution unit.
`timescale 1ns/100ps
`default_nettype none
module mem_console_model
	import exec_pkg::*;
#(
	parameter logic [0:17] VEC_WORD = 18'h0_0123
)
(
	// Clock and reset.
	input  wire logic        core_clk_in,
	input  wire logic        resetn_in,
	// Memory requests and answers.
	input  wire mem_req_s    mem_req_in,
	input  wire logic [3:0]  lat_in,
	output logic [0:17]      mem_rdata_out,
	output var logic         mem_rvalid_out,
	// Console controls from the bench.
	input  wire logic        cont_in,
	input  wire logic        restart_in,
	input  wire logic        prot_in,
	input  wire logic [0:17] acc_sw_in,
	input  wire logic [0:14] addr_sw_in,
	output logic             prot_mode_out,
	output console_s         console_out
);
	logic [0:17] word_r;
	logic [0:14] addr_r;
	logic [3:0]  wait_r;

	////////////////////////////////////////////////////////////////////////
	// Reads answer after a chosen latency, so slow memory can be shown.
	always_ff @(posedge core_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			wait_r <= 4'h0;
			addr_r <= '0;
			word_r <= '0;
			mem_rvalid_out <= 1'b0;
		end
		else
		begin
			mem_rvalid_out <= 1'b0;
			if (mem_req_in.rd)
			begin
				wait_r <= lat_in;
				addr_r <= mem_req_in.addr;
			end
			else if (wait_r != 4'h0)
			begin
				wait_r <= wait_r - 4'h1;
				if (wait_r == 4'h1)
				begin
					mem_rvalid_out <= 1'b1;
					word_r <= (addr_r == MON_VECTOR) ? VEC_WORD : 18'h0_0000;
				end
			end
		end
	end

	// A released data bus shows the inverse, so stale data never matches.
	assign mem_rdata_out = mem_rvalid_out ? word_r : ~word_r;
	assign prot_mode_out = prot_in;
	assign console_out = '{cont_in, restart_in, acc_sw_in, addr_sw_in};
endmodule
`default_nettype wire

// ==== verification/operate_skip_jump_index_exec_test.sv ====
// Self-checking bench for the operate, skip, jump and index unit.
`timescale 1ns/100ps
`default_nettype none
module operate_skip_jump_index_exec_test
	import exec_pkg::*;
;
	localparam logic [0:17] VEC_WORD = 18'h0_0123;
	logic core_clk, resetn, instr_valid, ready, done, mem_rvalid;
	logic prot_mode, halted, link, btn_cont, btn_restart, prot_sel;
	instr_s      instr;
	mem_req_s    mem_req;
	console_s    console;
	logic [0:17] mem_rdata, acc, index, limit, sw_acc, m_acc, m_idx, m_lim;
	logic [0:14] pc, sw_addr, m_pc;
	logic [2:0]  priority_interrupt_level;
	logic [3:0]  rd_lat;
	logic        m_link;
	int          bad_count, n_compared;
	op_e         rots [4];
	op_e         skips [6];
	op_e         xfer [6];

	operate_skip_jump_index_exec i_dut
	(
		.core_clk_in    (core_clk),
		.resetn_in      (resetn),
		.instr_valid_in (instr_valid),
		.instr_in       (instr),
		.ready_out      (ready),
		.done_out       (done),
		.mem_rdata_in   (mem_rdata),
		.mem_rvalid_in  (mem_rvalid),
		.prot_mode_in   (prot_mode),
		.mem_req_out    (mem_req),
		.console_in     (console),
		.halted_out     (halted),
		.pc_out         (pc),
		.acc_out        (acc),
		.link_out       (link),
		.index_out      (index),
		.limit_out      (limit),
		.api_level_out  (priority_interrupt_level)
	);

	mem_console_model #(.VEC_WORD(VEC_WORD)) i_mem
	(
		.core_clk_in    (core_clk),
		.resetn_in      (resetn),
		.mem_req_in     (mem_req),
		.lat_in         (rd_lat),
		.mem_rdata_out  (mem_rdata),
		.mem_rvalid_out (mem_rvalid),
		.cont_in        (btn_cont),
		.restart_in     (btn_restart),
		.prot_in        (prot_sel),
		.acc_sw_in      (sw_acc),
		.addr_sw_in     (sw_addr),
		.prot_mode_out  (prot_mode),
		.console_out    (console)
	);

	////////////////////////////////////////////////////////////////////////
	// Free-running 100 MHz clock.
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Case equality, so an unknown output never passes.
	task automatic chk(input logic [0:17] got, input logic [0:17] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Offers one instruction, predicts its effect and compares pc, acc, link, index and limit.
	// The ring model puts the link above accumulator bit 0.
	task automatic step(input op_e op, input logic [0:17] w = '0,
		input logic [0:14] e = '0, input logic ind = 1'b0);
		logic [18:0] r;
		logic [0:17] imm;
		logic [0:17] ret;
		logic [0:14] p;
		logic [0:14] a;
		int          k;
		r = {m_link, m_acc};
		imm = {{9{w[9]}}, w[9:17]};
		p = m_pc + PC_STEP;
		a = e;
		ret = {m_link, 1'b0, prot_sel, p};
		case (op)
			OP_ROTATE_RIGHT_ONE: r = {r[0], r[18:1]};
			OP_ROTATE_RIGHT_TWO: r = {r[1:0], r[18:2]};
			OP_ROTATE_LEFT_ONE: r = {r[17:0], r[18]};
			OP_ROTATE_LEFT_TWO: r = {r[16:0], r[18:17]};
			OP_LINK_COMPLEMENT: r[18] = ~r[18];
			OP_LINK_SET: r[18] = 1'b1;
			OP_LINK_CLEAR: r[18] = 1'b0;
			OP_ACC_CLEAR: r[17:0] = '0;
			OP_CONSOLE_OR_ACC: r[17:0] = r[17:0] | sw_acc;
			OP_ACC_INCREMENT: r = r + 19'h0_0001;
			OP_ACC_HALF_SWAP: r[17:0] = {r[8:0], r[17:9]};
			OP_ACC_INVERT: r[17:0] = ~r[17:0];
			OP_ACC_NEGATE: r[17:0] = ~r[17:0] + 18'h0_0001;
			OP_SELF_LOAD: r[17:0] = w;
			OP_EXECUTE_AT_EA: p = m_pc;
			OP_SKIP_ALWAYS: p = m_pc + PC_SKIP_STEP;
			OP_JUMP_INSTR: p = e;
			OP_JUMP_SUBROUTINE: p = e + PC_STEP;
			OP_MONITOR_CALL: a = ind ? VEC_WORD[3:17] : MON_VECTOR;
			OP_SKIP_ACC_POSITIVE: if (!r[17]) p = m_pc + PC_SKIP_STEP;
			OP_SKIP_ACC_NEGATIVE: if (r[17]) p = m_pc + PC_SKIP_STEP;
			OP_SKIP_ACC_NONZERO: if (r[17:0] != 0) p = m_pc + PC_SKIP_STEP;
			OP_SKIP_ACC_ZERO: if (r[17:0] == 0) p = m_pc + PC_SKIP_STEP;
			OP_SKIP_LINK_SET: if (r[18]) p = m_pc + PC_SKIP_STEP;
			OP_SKIP_LINK_CLEAR: if (!r[18]) p = m_pc + PC_SKIP_STEP;
			OP_ACC_TO_INDEX: m_idx = m_acc;
			OP_ACC_TO_LIMIT: m_lim = m_acc;
			OP_INDEX_TO_ACC: r[17:0] = m_idx;
			OP_INDEX_TO_LIMIT: m_lim = m_idx;
			OP_LIMIT_TO_ACC: r[17:0] = m_lim;
			OP_LIMIT_TO_INDEX: m_idx = m_lim;
			OP_ADD_ACC_IMM: r[17:0] = r[17:0] + imm;
			OP_ADD_INDEX_IMM: m_idx = m_idx + imm;
			OP_ADD_ACC_SKIP_LIMIT:
			begin
				r[17:0] = r[17:0] + imm;
				if ($signed(r[17:0]) >= $signed(m_lim)) p = m_pc + PC_SKIP_STEP;
			end
			OP_ADD_INDEX_SKIP_LIMIT:
			begin
				m_idx = m_idx + imm;
				if ($signed(m_idx) >= $signed(m_lim)) p = m_pc + PC_SKIP_STEP;
			end
			OP_INDEX_CLEAR: m_idx = '0;
			OP_LIMIT_CLEAR: m_lim = '0;
			default: ;
		endcase
		if (op == OP_MONITOR_CALL)
			p = a + PC_STEP;
		m_link = r[18];
		m_acc = r[17:0];
		@(negedge core_clk);
		instr_valid = 1'b1;
		instr = '{op, ind, w, e};
		// Results and request pulses stand for one cycle after the take.
		@(posedge core_clk);
		#1;
		// The indirect call first reads its vector and stops taking work.
		if (ind)
		begin
			chk(18'({mem_req.rd, ready, priority_interrupt_level}), 18'h0_0014);
			chk(18'(mem_req.addr), 18'(MON_VECTOR));
			@(negedge core_clk);
			instr_valid = 1'b0;
			for (k = 0; k < 40 && done !== 1'b1; k++)
			begin
				@(posedge core_clk);
				#1;
			end
			if (done !== 1'b1)
			begin
				bad_count++;
				complete_run();
			end
		end
		chk(18'(done), 18'h0_0001);
		chk(18'(pc), 18'(p));
		chk(acc, m_acc);
		chk(18'(link), 18'(m_link));
		chk(index, m_idx);
		chk(limit, m_lim);
		if (op == OP_JUMP_SUBROUTINE || op == OP_MONITOR_CALL)
		begin
			chk(18'({mem_req.wr, mem_req.addr}), 18'({1'b1, a}));
			chk(mem_req.data, ret);
		end
		if (op == OP_MONITOR_CALL)
			chk(18'(priority_interrupt_level), 18'(API_MON_LEVEL));
		if (op == OP_EXECUTE_AT_EA)
			chk(18'({mem_req.execute_at_ea, mem_req.addr}), 18'({1'b1, e}));
		m_pc = p;
		// Valid drops at the next falling edge, so each offer is taken once.
		@(negedge core_clk);
		instr_valid = 1'b0;
	endtask

	// Presses console buttons until the machine runs, then lets them go.
	task automatic press(input logic c, input logic rs);
		int k;
		@(negedge core_clk);
		btn_cont = c;
		btn_restart = rs;
		for (k = 0; k < 20 && ready !== 1'b1; k++)
			@(negedge core_clk);
		btn_cont = 1'b0;
		btn_restart = 1'b0;
		if (ready !== 1'b1)
		begin
			bad_count++;
			complete_run();
		end
		repeat (8) @(negedge core_clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence; the switch and vector values are plain test patterns.
	initial
	begin
		{resetn, instr_valid, btn_cont, btn_restart, prot_sel} = '0;
		instr = '0;
		sw_acc = 18'h2_4801;
		sw_addr = 15'h05A5;
		rd_lat = 4'h1;
		{m_acc, m_idx, m_lim, m_link, m_pc} = '0;
		bad_count = 0;
		n_compared = 0;
		rots = '{OP_ROTATE_RIGHT_ONE, OP_ROTATE_RIGHT_TWO,
			OP_ROTATE_LEFT_ONE, OP_ROTATE_LEFT_TWO};
		skips = '{OP_SKIP_ACC_POSITIVE, OP_SKIP_ACC_NEGATIVE, OP_SKIP_ACC_NONZERO,
			OP_SKIP_ACC_ZERO, OP_SKIP_LINK_SET, OP_SKIP_LINK_CLEAR};
		xfer = '{OP_ACC_TO_LIMIT, OP_ACC_TO_INDEX, OP_LIMIT_TO_INDEX,
			OP_INDEX_TO_ACC, OP_INDEX_TO_LIMIT, OP_LIMIT_TO_ACC};
		repeat (20) @(negedge core_clk);
		resetn = 1'b1;
		repeat (5) @(negedge core_clk);
		chk(18'({ready, halted, priority_interrupt_level}), 18'h0_0010);
		chk(acc | index | limit | 18'(pc), 18'h0_0000);
		step(OP_SELF_LOAD, 18'h0_1A5C);
		step(OP_ACC_INVERT);
		step(OP_LINK_SET);
		for (int j = 0; j < 8; j++)
			step(rots[j % 4]);
		step(OP_LINK_COMPLEMENT);
		step(OP_ACC_HALF_SWAP);
		step(OP_CONSOLE_OR_ACC);
		step(OP_ACC_NEGATE);
		step(OP_LINK_CLEAR);
		step(OP_NO_OPERATION);
		step(OP_ACC_CLEAR);
		step(OP_ACC_INVERT);
		step(OP_ACC_INCREMENT);
		foreach (skips[i])
			step(skips[i]);
		step(OP_ACC_INCREMENT);
		step(OP_ACC_INVERT);
		step(OP_LINK_COMPLEMENT);
		foreach (skips[i])
			step(skips[i]);
		foreach (xfer[i])
		begin
			step(OP_SELF_LOAD, 18'(i * 5 + 3));
			step(xfer[i]);
		end
		step(OP_SELF_LOAD, 18'h0_0050);
		step(OP_ACC_TO_LIMIT);
		step(OP_ADD_ACC_IMM, 18'h0_01FF);
		step(OP_ADD_ACC_SKIP_LIMIT, 18'h0_0001);
		step(OP_ADD_ACC_SKIP_LIMIT, 18'h0_01FF);
		step(OP_ACC_TO_INDEX);
		step(OP_ADD_INDEX_SKIP_LIMIT, 18'h0_0001);
		step(OP_ADD_INDEX_IMM, 18'h0_0100);
		step(OP_ADD_INDEX_SKIP_LIMIT, 18'h0_00F0);
		step(OP_INDEX_CLEAR);
		step(OP_LIMIT_CLEAR);
		step(OP_JUMP_INSTR, 18'h0_0000, 15'h1234);
		step(OP_SKIP_ALWAYS);
		@(negedge core_clk);
		prot_sel = 1'b1;
		step(OP_JUMP_SUBROUTINE, 18'h0_0000, 15'h0200);
		step(OP_EXECUTE_AT_EA, 18'h0_0000, 15'h0300);
		step(OP_SKIP_ALWAYS);
		step(OP_MONITOR_CALL, 18'h0_0000, 15'h7FFF);
		step(OP_MONITOR_CALL, 18'h0_0000, 15'h0000, 1'b1);
		@(negedge core_clk);
		rd_lat = 4'h6;
		step(OP_MONITOR_CALL, 18'h0_0000, 15'h0000, 1'b1);
		step(OP_HALT_INSTR);
		@(posedge core_clk);
		#1;
		chk(18'({halted, ready}), 18'h0_0002);
		// An instruction offered while halted must leave no trace.
		@(negedge core_clk);
		instr_valid = 1'b1;
		instr = '{OP_ACC_INVERT, 1'b0, 18'h0_0000, 15'h0000};
		repeat (3) @(negedge core_clk);
		instr_valid = 1'b0;
		chk(acc, m_acc);
		press(1'b1, 1'b0);
		chk(18'(pc), 18'(m_pc));
		step(OP_HALT_INSTR);
		press(1'b1, 1'b1);
		m_pc = sw_addr;
		chk(18'(pc), 18'(m_pc));
		step(OP_NO_OPERATION);
		complete_run();
	end
endmodule
`default_nettype wire
